/* File: verilog/rsq_rail_sequencer.sv */
// rsq_rail_sequencer: rail sequencer, delay registers, nvm commit and serial register port
`default_nettype none
module rsq_rail_sequencer #(
  parameter int unsigned MS_CYCLES = rsq_pkg::MS_CYCLES,
  parameter int unsigned CONV_TIME_MS = rsq_pkg::CONV_TIME_MS
) (
  // system
  input wire logic mclk,
  input wire logic reset_n,
  // serial register port, scl is the link clock
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // pins from the board and the analog side
  input wire logic en_pin,
  input wire logic common_pin,
  input wire logic supplies_ok,
  input wire logic fault_in,
  input wire logic [3:0] rail_feedback_ok,
  // rail controls and status
  output rsq_pkg::rsq_rails_t rails,
  output logic power_good,
  output logic common_out_switch,
  output logic temp_valid,
  output logic temp_busy
);
  // =====================================================================
  // state types
  typedef struct packed {
    logic [1:0] scl_s, sda_s, tg_s, en_s, cen_s, flt_s, sup_s;
    logic [1:0][3:0] good_s;
    logic sda_d, tg_d, sup_d, frame_rst;
    logic [7:0] ptr, level, rate, rd_data, written, nvm_level;
    logic [7:0][7:0] delay, nvm_delay;
    logic en_bit, cen_bit, temp_off, fault, cout, valid, busy, pgood;
    logic [4:0] level_commits;
    logic [1:0] delay_commits;
    rsq_pkg::rsq_seq_t seq;
    logic [16:0] tick;
    logic [9:0] ms;
    logic [13:0] conv;
    rsq_pkg::rsq_rails_t rails;
  } rsq_main_t;
  typedef struct packed {
    logic [3:0] bitcnt;
    logic [7:0] sh, tx, ptr;
    rsq_pkg::rsq_link_t phase;
    logic ack_en;
    logic [1:0][7:0] rd_s;
    logic [1:0] lvl_ok_s, dly_ok_s;
  } rsq_lk_t;
  typedef struct packed {
    logic tgl;
    rsq_pkg::rsq_byte_t b;
  } rsq_lh_t;

  rsq_main_t m, next_m;
  rsq_lk_t lk, next_lk;
  rsq_lh_t lh, next_lh;
  logic drive_q, next_drive;
  logic link_rst_n, lvl_ok, dly_ok, run, ms_tick, load_ev, byte_ev;
  logic [7:0] byte_in;
  logic refuse;

  // =====================================================================
  // helpers
  // conversion interval in ms; only the low three rate bits count
  function automatic logic [13:0] period_ms(input logic [7:0] rate);
    period_ms = 14'(rsq_pkg::SLOW_PERIOD_MS >> rate[2:0]);
  endfunction : period_ms

  function automatic logic is_delay(input logic [7:0] a);
    is_delay = (a >= rsq_pkg::ADDR_DELAY_FIRST) && (a <= rsq_pkg::ADDR_DELAY_LAST);
  endfunction : is_delay

  // =====================================================================
  // cross-domain levels and frame reset
  // the commit permissions are quasi-static and cross as levels into the link
  assign lvl_ok = m.level_commits < rsq_pkg::LEVEL_COMMITS_MAX;
  assign dly_ok = (m.delay_commits < rsq_pkg::DELAY_COMMITS_MAX) && (&m.written);
  // start or stop returns the link engine to its address phase
  assign link_rst_n = reset_n & ~m.frame_rst;
  assign run = (m.en_bit | m.en_s[1]) & ~m.fault;
  assign ms_tick = m.tick == 17'(MS_CYCLES - 1);
  assign load_ev = m.sup_s[1] & ~m.sup_d;
  assign byte_ev = m.tg_s[1] ^ m.tg_d;

  // =====================================================================
  // link domain: bit engine on rising scl
  always_comb begin
    next_lk = lk;
    next_lh = lh;
    byte_in = {lk.sh[6:0], sda_in};
    refuse = 1'b0;
    next_lk.rd_s = {lk.rd_s[0], m.rd_data};
    next_lk.lvl_ok_s = {lk.lvl_ok_s[0], lvl_ok};
    next_lk.dly_ok_s = {lk.dly_ok_s[0], dly_ok};
    if (lk.bitcnt == 4'h8) begin
      // acknowledge clock; in a read the host's nack ends the transfer
      next_lk.bitcnt = 4'h0;
      next_lk.ack_en = 1'b0;
      if (lk.phase == rsq_pkg::LK_READ) begin
        if (sda_in) begin
          next_lk.phase = rsq_pkg::LK_IGNORE;
        end else begin
          next_lk.tx = lk.rd_s[1];
        end
      end
    end else begin
      next_lk.sh = byte_in;
      next_lk.bitcnt = lk.bitcnt + 4'h1;
      if (lk.bitcnt == 4'h7) begin
        unique case (lk.phase)
          rsq_pkg::LK_ADDR: begin
            if (byte_in[7:1] == rsq_pkg::DEV_ADDR) begin
              next_lk.ack_en = 1'b1;
              next_lk.phase = byte_in[0] ? rsq_pkg::LK_READ : rsq_pkg::LK_PTR;
              next_lk.tx = lk.rd_s[1];
            end else begin
              next_lk.phase = rsq_pkg::LK_IGNORE;
            end
          end
          rsq_pkg::LK_PTR: begin
            next_lk.ack_en = 1'b1;
            next_lk.phase = rsq_pkg::LK_DATA;
            next_lk.ptr = byte_in;
            next_lh.tgl = ~lh.tgl;
            next_lh.b = '{is_ptr: 1'b1, data: byte_in};
          end
          rsq_pkg::LK_DATA: begin
            // a commit past its limit is not forwarded and is answered with nack
            refuse = (lk.ptr == rsq_pkg::ADDR_COMMIT) &&
                     ((byte_in[rsq_pkg::COMMIT_LEVEL_BIT] && !lk.lvl_ok_s[1]) ||
                      (byte_in[rsq_pkg::COMMIT_DELAY_BIT] && !lk.dly_ok_s[1]));
            next_lk.ack_en = ~refuse;
            next_lk.ptr = lk.ptr + 8'h01;
            if (!refuse) begin
              next_lh.tgl = ~lh.tgl;
              next_lh.b = '{is_ptr: 1'b0, data: byte_in};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // sda is only changed on falling scl so it never moves while scl is high
  always_comb begin
    next_drive = ((lk.bitcnt == 4'h8) && lk.ack_en) ||
                 ((lk.phase == rsq_pkg::LK_READ) && (lk.bitcnt < 4'h8) &&
                  !lk.tx[~lk.bitcnt[2:0]]);
  end

  // link registers; frame state restarts on every start or stop
  always_ff @(posedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // the handoff toggle survives frame resets so no false byte event appears
  always_ff @(posedge scl or negedge reset_n) begin
    if (!reset_n) begin
      lh <= '0;
    end else begin
      lh <= next_lh;
    end
  end

  always_ff @(negedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= next_drive;
    end
  end

  assign sda_oe = drive_q;
  assign sda_out = 1'b0;

  // =====================================================================
  // main domain: synchronisers, register file, nvm, sequencer, sensor timing
  always_comb begin
    next_m = m;
    next_m.scl_s = {m.scl_s[0], scl};
    next_m.sda_s = {m.sda_s[0], sda_in};
    next_m.tg_s = {m.tg_s[0], lh.tgl};
    next_m.en_s = {m.en_s[0], en_pin};
    next_m.cen_s = {m.cen_s[0], common_pin};
    next_m.flt_s = {m.flt_s[0], fault_in};
    next_m.sup_s = {m.sup_s[0], supplies_ok};
    next_m.good_s = {m.good_s[0], rail_feedback_ok};
    next_m.sda_d = m.sda_s[1];
    next_m.tg_d = m.tg_s[1];
    next_m.sup_d = m.sup_s[1];
    // sda moving while scl is high is a start or a stop
    if (m.scl_s[1] && (m.sda_d != m.sda_s[1])) begin
      next_m.frame_rst = 1'b1;
    end else if (!m.scl_s[1]) begin
      next_m.frame_rst = 1'b0;
    end
    next_m.tick = ms_tick ? 17'h0 : m.tick + 17'h1;
    if (ms_tick && (m.ms != 10'h3ff)) begin
      next_m.ms = m.ms + 10'h001;
    end
    // register writes arrive as bytes from the link
    if (byte_ev) begin
      if (lh.b.is_ptr) begin
        next_m.ptr = lh.b.data;
      end else begin
        next_m.ptr = m.ptr + 8'h01;
        if (is_delay(m.ptr)) begin
          next_m.delay[m.ptr[2:0]] = lh.b.data;
          next_m.written[m.ptr[2:0]] = 1'b1;
        end
        unique case (m.ptr)
          rsq_pkg::ADDR_CONFIG: begin
            next_m.temp_off = lh.b.data[rsq_pkg::CONFIG_SHUTDOWN_BIT];
            if (m.temp_off && !lh.b.data[rsq_pkg::CONFIG_SHUTDOWN_BIT]) begin
              next_m.conv = 14'h0;
              next_m.valid = 1'b0;
            end
          end
          rsq_pkg::ADDR_LEVEL: next_m.level = lh.b.data;
          rsq_pkg::ADDR_ENABLE: begin
            next_m.en_bit = lh.b.data[rsq_pkg::ENABLE_RAILS_BIT];
            next_m.cen_bit = lh.b.data[rsq_pkg::ENABLE_COMMON_BIT];
          end
          rsq_pkg::ADDR_COMMIT: begin
            if (lh.b.data[rsq_pkg::COMMIT_LEVEL_BIT] && lvl_ok) begin
              next_m.nvm_level = m.level;
              next_m.level_commits = m.level_commits + 5'h01;
            end
            if (lh.b.data[rsq_pkg::COMMIT_DELAY_BIT] && dly_ok) begin
              next_m.nvm_delay = m.delay;
              next_m.delay_commits = m.delay_commits + 2'h1;
              next_m.written = 8'h00;
            end
          end
          rsq_pkg::ADDR_RATE: next_m.rate = lh.b.data;
          default: begin
          end
        endcase
      end
    end
    // leaving lockout reloads the presets and starts a first conversion
    if (load_ev) begin
      next_m.delay = m.nvm_delay;
      next_m.level = m.nvm_level;
      next_m.conv = 14'h0;
      next_m.valid = 1'b0;
    end else if (!m.temp_off && ms_tick) begin
      next_m.conv = (m.conv == period_ms(m.rate) - 14'h1) ? 14'h0 : m.conv + 14'h1;
      if (m.conv == 14'(CONV_TIME_MS - 1)) begin
        next_m.valid = 1'b1;
      end
    end
    next_m.busy = !m.temp_off && (m.conv < 14'(CONV_TIME_MS));
    // rail sequencer
    unique case (m.seq)
      rsq_pkg::SEQ_OFF: begin
        if (run && m.sup_s[1]) begin
          next_m.seq = rsq_pkg::SEQ_BOOST;
          next_m.rails = '0;
          next_m.rails.boost = 1'b1;
          next_m.ms = 10'h0;
        end
      end
      rsq_pkg::SEQ_BOOST: begin
        if (m.ms == 10'(rsq_pkg::BOOST_SS_MS)) begin
          next_m.seq = rsq_pkg::SEQ_INV;
          next_m.rails.inverting = 1'b1;
          next_m.ms = 10'h0;
        end
      end
      rsq_pkg::SEQ_INV: begin
        if (m.ms == 10'(rsq_pkg::INV_SS_MS)) begin
          next_m.seq = rsq_pkg::SEQ_UP;
          next_m.ms = 10'h0;
        end
      end
      rsq_pkg::SEQ_UP: begin
        for (int i = 0; i < 4; i++) begin
          if (m.ms >= {2'b00, m.delay[i]}) begin
            next_m.rails.rails_on[i] = 1'b1;
          end
        end
        if (&m.rails.rails_on) begin
          next_m.seq = rsq_pkg::SEQ_ON;
          next_m.ms = 10'h0;
        end
      end
      rsq_pkg::SEQ_ON: begin
      end
      rsq_pkg::SEQ_DOWN: begin
        // a new start request waits until the converters are fully off
        for (int i = 0; i < 4; i++) begin
          if (m.ms >= {2'b00, m.delay[4 + i]}) begin
            next_m.rails.rails_on[i] = 1'b0;
            next_m.rails.discharge[i] = 1'b1;
          end
        end
        if (m.ms >= 10'(rsq_pkg::SHUTDOWN_MS)) begin
          next_m.rails.boost = 1'b0;
          next_m.rails.inverting = 1'b0;
          next_m.seq = rsq_pkg::SEQ_OFF;
        end
      end
      rsq_pkg::SEQ_FAULT: begin
      end
      default: next_m.seq = rsq_pkg::SEQ_FAULT;
    endcase
    if (!run && (m.seq inside {rsq_pkg::SEQ_BOOST, rsq_pkg::SEQ_INV, rsq_pkg::SEQ_UP,
                               rsq_pkg::SEQ_ON})) begin
      next_m.seq = rsq_pkg::SEQ_DOWN;
      next_m.ms = 10'h0;
    end
    next_m.pgood = (m.seq == rsq_pkg::SEQ_ON) && run && (&m.good_s[1]) &&
                   (m.ms >= 10'(rsq_pkg::RAIL_SS_MS));
    next_m.cout = (m.cen_bit | m.cen_s[1]) & ~m.fault;
    // a fault latches the rails, power good, common switch and enable bits off until reset; sensor timing keeps running
    if (m.flt_s[1] || m.fault) begin
      next_m.fault = 1'b1;
      next_m.seq = rsq_pkg::SEQ_FAULT;
      next_m.rails = '0;
      next_m.pgood = 1'b0;
      next_m.cout = 1'b0;
      next_m.en_bit = 1'b0;
      next_m.cen_bit = 1'b0;
    end
    // read data follows the pointer; the commit register reads zero
    unique case (m.ptr)
      rsq_pkg::ADDR_CONFIG: next_m.rd_data = {7'h00, m.temp_off};
      rsq_pkg::ADDR_TEMP_STATUS: next_m.rd_data = {7'h00, m.busy};
      rsq_pkg::ADDR_LEVEL: next_m.rd_data = m.level;
      rsq_pkg::ADDR_ENABLE: next_m.rd_data = {6'h00, m.cen_bit, m.en_bit};
      rsq_pkg::ADDR_FAULT: next_m.rd_data = {m.pgood, 6'h00, m.fault};
      rsq_pkg::ADDR_RATE: next_m.rd_data = m.rate;
      default: next_m.rd_data = is_delay(m.ptr) ? m.delay[m.ptr[2:0]] : 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      m <= '0;
      m.rate <= rsq_pkg::RATE_RESET;
      m.nvm_level <= rsq_pkg::LEVEL_NVM_DEFAULT;
      m.nvm_delay <= rsq_pkg::DELAY_NVM_DEFAULT;
    end else begin
      m <= next_m;
    end
  end

  assign rails = m.rails;
  assign power_good = m.pgood;
  assign common_out_switch = m.cout;
  assign temp_valid = m.valid;
  assign temp_busy = m.busy;

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  rate_low_bits_a: assert property (m.conv < period_ms(m.rate))
    else $error("conversion counter passed its interval");
  valid_after_conv_a: assert property ($rose(m.valid) |-> m.conv == 14'(CONV_TIME_MS))
    else $error("result valid before a full conversion");
  boost_start_a: assert property ((m.seq == rsq_pkg::SEQ_OFF && run && m.sup_s[1] &&
    !m.flt_s[1]) |=> m.rails.boost)
    else $error("boost did not start on request");
  inv_after_boost_a: assert property ($rose(m.rails.inverting) |->
    $past(m.ms) == 10'(rsq_pkg::BOOST_SS_MS))
    else $error("inverting rail started early");
  rail_delay_a: assert property ($rose(m.rails.rails_on[0]) |->
    $past(m.ms) >= {2'b00, $past(m.delay[0])})
    else $error("gate low rail started before its delay");
  pgood_cause_a: assert property ($rose(m.pgood) |->
    $past(&m.good_s[1]) && $past(m.seq) == rsq_pkg::SEQ_ON)
    else $error("power good without feedbacks");
  pgood_drop_a: assert property ((m.pgood && !run) |=> !m.pgood)
    else $error("power good held after stop");
  converters_off_a: assert property ($fell(m.rails.boost) |->
    $past(m.ms) >= 10'(rsq_pkg::SHUTDOWN_MS) || $past(m.flt_s[1] || m.fault))
    else $error("converters off before shutdown delay");
  load_presets_a: assert property (load_ev && !m.flt_s[1] |=> m.delay == $past(m.nvm_delay))
    else $error("delays not loaded from nvm");
  level_limit_a: assert property (m.level_commits <= rsq_pkg::LEVEL_COMMITS_MAX)
    else $error("too many level commits");
  delay_commit_a: assert property ($changed(m.nvm_delay) |->
    $past(m.written) == 8'hff && m.written == 8'h00)
    else $error("delay commit without all writes");
  fault_off_a: assert property (m.fault |=> !m.en_bit && !m.pgood && m.rails == '0)
    else $error("fault did not latch outputs off");

  on_cover_c: cover property (m.seq == rsq_pkg::SEQ_ON && m.pgood);
  down_cover_c: cover property (m.seq == rsq_pkg::SEQ_DOWN ##1 m.seq == rsq_pkg::SEQ_OFF);
  commit_cover_c: cover property ($changed(m.nvm_level));
  refuse_cover_c: cover property (m.level_commits == rsq_pkg::LEVEL_COMMITS_MAX);
endmodule : rsq_rail_sequencer
`default_nettype wire

/* File: verilog/rsq_pkg.sv */
// rsq_pkg: shared constants, encodings and carrier types of the rail sequencer
`default_nettype none
package rsq_pkg;
  // =====================================================================
  // timebase
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned BOOST_SS_MS = 10;
  localparam int unsigned INV_SS_MS = 10;
  localparam int unsigned RAIL_SS_MS = 10;
  localparam int unsigned SHUTDOWN_MS = 512;
  localparam int unsigned CONV_TIME_MS = 100;
  localparam int unsigned SLOW_PERIOD_MS = 16000;
  // =====================================================================
  // register map of the serial port
  localparam logic [7:0] ADDR_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_TEMP_STATUS = 8'h05;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h09;
  localparam logic [7:0] ADDR_FAULT = 8'h0a;
  localparam logic [7:0] ADDR_COMMIT = 8'h0c;
  localparam logic [7:0] ADDR_RATE = 8'h0f;
  localparam logic [7:0] ADDR_DELAY_FIRST = 8'h10;
  localparam logic [7:0] ADDR_DELAY_LAST = 8'h17;
  localparam int unsigned COMMIT_LEVEL_BIT = 0;
  localparam int unsigned COMMIT_DELAY_BIT = 1;
  localparam int unsigned ENABLE_RAILS_BIT = 0;
  localparam int unsigned ENABLE_COMMON_BIT = 1;
  localparam int unsigned CONFIG_SHUTDOWN_BIT = 0;
  // =====================================================================
  // reset and factory values
  localparam logic [7:0] RATE_RESET = 8'h04;
  localparam logic [7:0] LEVEL_NVM_DEFAULT = 8'h7f;
  localparam logic [7:0][7:0] DELAY_NVM_DEFAULT =
    {8'h78, 8'h5a, 8'h3c, 8'h1e, 8'h78, 8'h5a, 8'h3c, 8'h1e};
  localparam logic [4:0] LEVEL_COMMITS_MAX = 5'h1e;
  localparam logic [1:0] DELAY_COMMITS_MAX = 2'h3;
  localparam logic [6:0] DEV_ADDR = 7'h3a; // arbitrary value
  // =====================================================================
  // encodings and carriers
  typedef enum logic [2:0] {
    SEQ_OFF = 3'b000, SEQ_BOOST = 3'b001, SEQ_INV = 3'b010, SEQ_UP = 3'b011,
    SEQ_ON = 3'b100, SEQ_DOWN = 3'b101, SEQ_FAULT = 3'b110
  } rsq_seq_t;
  typedef enum logic [2:0] {
    LK_ADDR = 3'b000, LK_PTR = 3'b001, LK_DATA = 3'b010, LK_READ = 3'b011,
    LK_IGNORE = 3'b100
  } rsq_link_t;
  typedef struct packed {
    logic boost;
    logic inverting;
    logic [3:0] rails_on;  // gate_low, source_minus, source_plus, gate_high
    logic [3:0] discharge;
  } rsq_rails_t;
  typedef struct packed {
    logic is_ptr;
    logic [7:0] data;
  } rsq_byte_t;
endpackage : rsq_pkg
`default_nettype wire

/* File: sim/rsq_host.sv */
// rsq_host: serial host model that frames each transfer on its own scl
`default_nettype none
module rsq_host (
  // wire side
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: clock stands high and the line is released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ==========
  // bit and frame primitives, 80 ns per bit, data moves in the low phase
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #20 sda_low = !b;
    #20 scl = 1'b1;
    r = sda;
    #40;
  endtask : bit_io
  task automatic start();
    scl = 1'b1;
    #20 sda_low = 1'b1;
    #20;
  endtask : start
  task automatic stop();
    scl = 1'b0;
    #20 sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #40;
  endtask : stop
  // one byte msb first, then the answer bit; last=1 releases the ninth bit
  task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r,
                      output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(last, nak);
  endtask : xfer
  // ==========
  // register access: pointer then n data bytes, nak collects any refusal
  task automatic wr(input logic [7:0] a, input logic [63:0] d, input int n,
                    output logic nak);
    logic [7:0] r;
    logic k;
    start();
    xfer({rsq_pkg::DEV_ADDR, 1'b0}, 1'b1, r, nak);
    xfer(a, 1'b1, r, k);
    nak = nak | k;
    for (int j = 0; j < n; j++) begin
      xfer(d[8*j+:8], 1'b1, r, k);
      nak = nak | k;
    end
    stop();
  endtask : wr
  // a stop between pointer and read keeps the device's settle time
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic k;
    wr(a, 64'h0, 0, k);
    start();
    xfer({rsq_pkg::DEV_ADDR, 1'b1}, 1'b1, v, k);
    xfer(8'hff, 1'b1, v, k);
    stop();
  endtask : rd
endmodule : rsq_host
`default_nettype wire

/* File: sim/rsq_rail_sequencer_tb.sv */
// rsq_rail_sequencer_tb: self-checking bench of the rail sequencer
`default_nettype none
module rsq_rail_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  logic mclk, reset_n, en_pin, common_pin, supplies_ok, fault_in, nak;
  logic scl, host_low, sda_out, sda_oe, power_good, com_sw, temp_valid, temp_busy;
  logic [3:0] fb_ok;
  logic [31:0] seed;
  logic [63:0] d, e;
  logic [10:0] p, p0;
  logic [7:0] r;
  int bad_count, compares, t[11], c, m;
  rsq_pkg::rsq_rails_t rails;
  wire sda;
  // open-drain line with pull-up: low while anyone pulls
  assign sda = !(host_low | sda_oe);
  rsq_host host (.scl(scl), .sda_low(host_low), .sda(sda));
  rsq_rail_sequencer #(.MS_CYCLES(MS)) uut (.mclk(mclk), .reset_n(reset_n), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .en_pin(en_pin),
    .common_pin(common_pin), .supplies_ok(supplies_ok), .fault_in(fault_in),
    .rail_feedback_ok(fb_ok), .rails(rails), .power_good(power_good),
    .common_out_switch(com_sw), .temp_valid(temp_valid), .temp_busy(temp_busy));
  // 125 MHz main clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ==========
  // checking helpers
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // an event expected at ms milliseconds, two ms of slack for sync and rounding
  function automatic logic near(input int got, input int ms);
    return got >= (ms - 2) * MS && got <= (ms + 2) * MS;
  endfunction : near
  // first cycle at which each of pg, boost, inverting, rails_on, discharge changes
  task automatic watch(input int lim);
    p0 = {power_good, rails};
    for (int i = 0; i < 11; i++) t[i] = -1;
    for (c = 0; c < lim; c++) begin
      @(posedge mclk);
      // look just after the edge so the value launched by it has settled
      #1;
      p = {power_good, rails};
      for (int i = 0; i < 11; i++) if (t[i] < 0 && p[i] !== p0[i]) t[i] = c;
    end
  endtask : watch
  // ==========
  // main sequence
  initial begin
    {reset_n, en_pin, common_pin, supplies_ok, fault_in} = 5'h00;
    fb_ok = 4'h7;
    seed = 32'h1adb;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    supplies_ok <= 1'b1;
    for (c = 0; c < 120 * MS && temp_valid !== 1'b1; c++) @(posedge mclk);
    chk(near(c, 100), "temp result delay");
    if (c >= 120 * MS) close_out();
    repeat (2) @(posedge mclk);
    chk(temp_busy === 1'b0, "busy clears after conversion");
    host.rd(8'h0f, r);
    chk(r === 8'h04, "rate reset");
    for (int i = 0; i < 8; i++) begin
      host.rd(8'h10 + 8'(i), r);
      chk(r === 8'(30 * (i % 4 + 1)), "factory delay");
    end
    host.rd(8'h0c, r);
    chk(r === 8'h00, "commit reads zero");
    $display("test presets done");
    // corner delays 0 and 255 among random ones
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d[8*i+:8] = {3'h0, seed[4:0]} + 8'h01;
    end
    d[7:0] = 8'h00;
    d[63:56] = 8'hff;
    host.wr(8'h10, d, 8, nak);
    // the pin starts the rails here so the watch window opens on the request
    @(posedge mclk);
    en_pin <= 1'b1;
    watch(70 * MS);
    chk(t[9] >= 0 && t[9] < 8, "boost start");
    chk(near(t[8], 10), "inverting start");
    for (int i = 0; i < 4; i++) chk(near(t[4+i], 20 + d[8*i+:8]), "rail start");
    chk(t[10] < 0, "pg held by feedback");
    fb_ok <= 4'hf;
    repeat (10) @(posedge mclk);
    chk(power_good === 1'b1, "pg rises");
    $display("test power up done");
    // host keeps the rails up while committing
    host.wr(8'h08, 64'h5c, 1, nak);
    for (int i = 0; i < 31; i++) begin
      host.wr(8'h0c, 64'h01, 1, nak);
      chk(nak === (i == 30), "level commit answer");
    end
    host.wr(8'h0c, 64'h02, 1, nak);
    chk(nak === 1'b0, "delay commit taken");
    host.wr(8'h0c, 64'h02, 1, nak);
    chk(nak === 1'b1, "commit needs fresh writes");
    $display("test commits done");
    @(posedge mclk);
    en_pin <= 1'b0;
    watch(530 * MS);
    chk(t[10] >= 0 && t[10] < 4, "pg drops");
    for (int i = 0; i < 4; i++) chk(near(t[i], d[8*(4+i)+:8]), "discharge time");
    chk(near(t[9], 512) && near(t[8], 512), "converters off");
    $display("test power down done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      e[8*i+:8] = seed[7:0];
    end
    for (int k = 0; k < 3; k++) begin
      host.wr(8'h10, (k == 2) ? d : e, 8, nak);
      host.wr(8'h0c, 64'h02, 1, nak);
      chk(nak === (k == 2), "delay commit limit");
    end
    @(posedge mclk);
    supplies_ok <= 1'b0;
    repeat (10) @(posedge mclk);
    supplies_ok <= 1'b1;
    repeat (10) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      host.rd(8'h10 + 8'(i), r);
      chk(r === e[8*i+:8], "stored delay");
    end
    host.rd(8'h08, r);
    chk(r === 8'h5c, "stored level");
    $display("test reload done");
    common_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(com_sw === 1'b1, "common pin");
    // both enable bits set by the bus, pin left low
    host.wr(8'h09, 64'h03, 1, nak);
    repeat (25 * MS) @(posedge mclk);
    chk(rails.boost === 1'b1 && rails.inverting === 1'b1, "enable bit starts rails");
    fault_in <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(rails === '0 && power_good === 1'b0 && com_sw === 1'b0, "fault off");
    host.rd(8'h09, r);
    chk(r === 8'h00, "fault clears enables");
    $display("test fault done");
    close_out();
  end
endmodule : rsq_rail_sequencer_tb
`default_nettype wire
